/* display_fifo.sv */
// Purpose: Display data FIFO between DMA writes and pixel output
// Assumes: One clock, synchronous active-high reset and flush
// Notes: Forced pop of an empty FIFO still advances and returns stale data
`timescale 1ns/100ps
module display_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  input wire logic force_pop,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  // Flags and handshakes
  assign level = wr_q - rd_q;
  assign in_ready = (level != DEPTH[AW:0]) && !flush;
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = (out_valid && out_ready) || force_pop;
  assign out_data = mem[rd_q[AW-1:0]];
  // Storage and pointers
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : display_fifo

/* dma_source_model.sv */
// Purpose: DMA controller model feeding the display FIFO window
// Assumes: One threshold of words per event
// Notes: Delay input makes late loads; reprogram drops pending words
`timescale 1ns/100ps
`include "raw_display_map.svh"
module dma_source_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic reprogram,
  input wire logic [15:0] dma_delay,
  input wire logic luma_dma_event,
  input wire logic [`THR_W-1:0] display_fifo_threshold,
  input wire logic luma_fifo_window_ready,
  output logic luma_fifo_window_valid,
  output logic [`SAMPLE_W-1:0] luma_fifo_window
);
  int pend;
  int wait_cnt;
  logic [`SAMPLE_W-1:0] word;
  initial begin
    pend = 0;
    wait_cnt = 0;
    word = 20'h00001;
    luma_fifo_window_valid = 1'b0;
    luma_fifo_window = ~word;
    forever begin
      @(posedge clk);
      if (luma_fifo_window_valid && luma_fifo_window_ready) begin
        word = word + 1'b1;
        pend--;
      end
      if (luma_dma_event) begin
        pend += int'(display_fifo_threshold);
        wait_cnt = int'(dma_delay);
      end
      if (wait_cnt > 0) wait_cnt--;
      if (rst || reprogram) pend = 0;
      #1;
      luma_fifo_window_valid = pend > 0 && wait_cnt == 0;
      luma_fifo_window = luma_fifo_window_valid ? word : ~word;
    end
  end
endmodule : dma_source_model

/* raw_display_channel.sv */
// Purpose: Raw video display channel: timing, DMA requests, FIFO streaming, status
// Assumes: DMA writes arrive on the FIFO port; software drives the controls as ports
// Notes: Completion flags clear by one-cycle clear pulses; set wins over clear
// Behaviour
// - Mode 01x gives narrow raw samples, 11x gives wide raw samples.
// - Display starts at the second frame start after disable drops, with first selected field.
// - DMA requests follow FIFO threshold and a per-field event counter.
// - At last line and pixel set field or frame done and complete flag.
// - Complete flag interrupts only while its enable is set.
// - Continuous mode resumes at next field or frame automatically.
// - Non-continuous: uncleared done flag at next completion raises not-acknowledged.
// - Empty FIFO during an active line sets the under-run flag.
// - Under-run interrupts only while its enable is set.
// - On under-run the read pointer advances and stale data still goes out.
// - A late load within one threshold recovers; otherwise the field is corrupt.
// - Block disable flushes the FIFO and blocks DMA events.
// - Counters keep running during block disable.
// - Clearing block disable re-enables events only from the frame after next.
// - Threshold control carries FIFO threshold and pixel increment rate.
// - Hsync asserts at a set pixel and lasts a set pixel count.
// - Vblank and vsync start and stop at programmed line and pixel per field.
// - Field one and two start line and pixel are programmable.
// - Writing one clears a completion flag; zero leaves it.
// - Completion flags set on the same edge that registers the final pixel out.
`timescale 1ns/100ps
module raw_display_channel
  import raw_display_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic display_enable_bit,
  input wire logic block_disable,
  input wire logic [`MODE_W-1:0] display_format_select,
  input wire logic continuous_select,
  input wire logic frame_select,
  input wire logic field_one_select,
  input wire logic field_two_select,
  input wire logic ten_bit_unpack,
  input wire logic [`THR_W-1:0] display_fifo_threshold,
  input wire logic pixel_increment_rate,
  input wire logic [`CNT_W-1:0] frame_width,
  input wire logic [`CNT_W-1:0] frame_height,
  input wire logic [`CNT_W-1:0] hblank_start,
  input wire logic [`CNT_W-1:0] hblank_stop,
  input wire logic [`CNT_W-1:0] hsync_start_pixel,
  input wire logic [`CNT_W-1:0] hsync_width,
  input wire logic [2*`CNT_W-1:0] vblank_start_1,
  input wire logic [2*`CNT_W-1:0] vblank_stop_1,
  input wire logic [2*`CNT_W-1:0] vblank_start_2,
  input wire logic [2*`CNT_W-1:0] vblank_stop_2,
  input wire logic [2*`CNT_W-1:0] vsync_start_1,
  input wire logic [2*`CNT_W-1:0] vsync_stop_1,
  input wire logic [2*`CNT_W-1:0] vsync_start_2,
  input wire logic [2*`CNT_W-1:0] vsync_stop_2,
  input wire logic [2*`CNT_W-1:0] field_one_start_pos,
  input wire logic [2*`CNT_W-1:0] field_two_start_pos,
  input wire logic [`EVT_W-1:0] field_one_event_count,
  input wire logic [`EVT_W-1:0] field_two_event_count,
  input wire logic [`SAMPLE_W-1:0] default_value,
  input wire logic underrun_irq_enable,
  input wire logic complete_irq_enable,
  input wire logic clear_field_one_done,
  input wire logic clear_field_two_done,
  input wire logic clear_frame_done,
  input wire logic clear_underrun,
  input wire logic clear_not_ack,
  input wire logic clear_display_complete,
  input wire logic luma_fifo_window_valid,
  input wire logic [`SAMPLE_W-1:0] luma_fifo_window,
  output logic luma_fifo_window_ready,
  output logic luma_dma_event,
  output logic [`SAMPLE_W-1:0] pixel_out,
  output logic pixel_valid,
  output logic hsync,
  output logic vsync,
  output logic vblank,
  output logic field_id,
  output logic [`CNT_W-1:0] frame_pixel_counter,
  output logic [`CNT_W-1:0] frame_line_counter,
  output logic field_one_done,
  output logic field_two_done,
  output logic frame_done,
  output logic display_complete_flag,
  output logic completion_not_acknowledged,
  output logic underrun_flag,
  output logic interrupt
);
  disp_reg_t q;
  disp_reg_t d;
  logic [`SAMPLE_W-1:0] fifo_data;
  logic fifo_valid;
  logic [`FIFO_AW:0] fifo_level;
  logic [`CNT_W-1:0] h_lo;
  logic [`CNT_W-1:0] h_hi;
  logic [2*`CNT_W-1:0] pos;
  logic step;
  logic pix_end;
  logic frame_end;
  logic active;
  logic showing;
  logic fld_sel;
  logic [`SAMPLE_W-1:0] sample;

  display_fifo #(
    .WIDTH(`SAMPLE_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(block_disable),
    .in_valid(luma_fifo_window_valid),
    .in_ready(luma_fifo_window_ready),
    .in_data(luma_fifo_window),
    .out_valid(fifo_valid),
    .out_ready(1'b0),
    // Pop in the same cycle the sample is taken, so no word is shown twice
    .force_pop(d.pop),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // Timing decode
  always_comb begin
    pos = {q.line, q.pix};
    step = pixel_increment_rate ? q.pix_phase : 1'b1;
    pix_end = step && (q.pix == frame_width);
    frame_end = pix_end && (q.line == frame_height);
    h_lo = (hblank_stop < hblank_start) ? hblank_stop : hblank_start;
    h_hi = (hblank_stop < hblank_start) ? hblank_start : hblank_stop;
    // Blanking either inside the line or wrapping through pixel zero
    if (hblank_stop > hblank_start) begin
      active = !q.vblank && !(q.pix >= h_lo && q.pix < h_hi);
    end else begin
      active = !q.vblank && (q.pix >= hblank_stop) && (q.pix < hblank_start);
    end
    fld_sel = q.field_two ? field_two_select : field_one_select;
    showing = (q.state == ST_SHOW) && (fld_sel || frame_select);
    case (display_format_select[`MODE_W-1:1])
      `MODE_RAW_NARROW: sample = ten_bit_unpack ? {10'h000, fifo_data[9:0]} : {12'h000, fifo_data[7:0]};
      `MODE_RAW_WIDE: sample = fifo_data;
      default: sample = default_value;
    endcase
  end

  // Next-state logic
  always_comb begin
    d = q;
    d.luma_dma_event = 1'b0;
    d.pop = 1'b0;
    d.pix_phase = q.pix_phase ^ pixel_increment_rate;
    if (step) begin
      d.pix = pix_end ? '0 : q.pix + 1'b1;
      if (pix_end) begin
        d.line = (q.line == frame_height) ? '0 : q.line + 1'b1;
      end
    end
    if (pos == field_two_start_pos) begin
      d.field_two = 1'b1;
    end else if (pos == field_one_start_pos) begin
      d.field_two = 1'b0;
    end
    if (step && q.pix == hsync_start_pixel) begin
      d.hsync = 1'b1;
      d.hsync_cnt = hsync_width;
    end else if (step && q.hsync) begin
      d.hsync_cnt = q.hsync_cnt - 1'b1;
      d.hsync = (q.hsync_cnt > `CNT_W'(1));
    end
    if (pos == (q.field_two ? vblank_start_2 : vblank_start_1)) begin
      d.vblank = 1'b1;
    end else if (pos == (q.field_two ? vblank_stop_2 : vblank_stop_1)) begin
      d.vblank = 1'b0;
    end
    if (pos == (q.field_two ? vsync_start_2 : vsync_start_1)) begin
      d.vsync = 1'b1;
    end else if (pos == (q.field_two ? vsync_stop_2 : vsync_stop_1)) begin
      d.vsync = 1'b0;
    end
    // re-arm only at the frame after clearing
    d.blk_prev = block_disable;
    if (block_disable) begin
      d.rearm = 1'b0;
    end else if (q.blk_prev) begin
      d.rearm = 1'b1;
    end
    // Display sequencing
    case (q.state)
      ST_IDLE: begin
        if (display_enable_bit) begin
          d.state = ST_WAIT_FRAME;
        end
      end
      ST_WAIT_FRAME: begin
        // start at next frame
        // Previous disable level keeps a same-cycle drop from starting early
        if (!block_disable && !q.blk_prev && !q.rearm && frame_end) begin
          d.state = ST_SHOW;
          d.evt_left = field_one_select ? field_one_event_count : field_two_event_count;
        end else if (frame_end && q.rearm) begin
          d.rearm = 1'b0;
        end
      end
      ST_SHOW: begin
        if (block_disable || !display_enable_bit) begin
          d.state = display_enable_bit ? ST_WAIT_FRAME : ST_IDLE;
        end
      end
      default: begin
        // non-continuous also shows the next one
        d.state = ST_SHOW;
      end
    endcase
    // threshold and event counter
    // Credit of words requested and not yet shown
    if (q.pop) begin
      d.since_req = (q.since_req != '0) ? q.since_req - 1'b1 : '0;
    end
    // Request while one more threshold still fits in the FIFO
    if (showing && !block_disable && q.evt_left != '0
      && d.since_req <= (`THR_W+1)'(`FIFO_DEPTH) - {1'b0, display_fifo_threshold}) begin
      d.luma_dma_event = 1'b1;
      d.evt_left = q.evt_left - 1'b1;
      d.since_req = d.since_req + {1'b0, display_fifo_threshold};
    end
    // Flushed FIFO holds nothing requested
    if (block_disable) begin
      d.since_req = '0;
    end
    d.pixel_valid = showing && active;
    if (showing && active && step) begin
      d.pop = 1'b1;
      d.pixel_out = sample;
    end else if (!showing) begin
      d.pixel_out = default_value;
    end
    if (showing && active && step && !fifo_valid) begin
      d.late = 1'b1;
    end else if (fifo_level >= {1'b0, display_fifo_threshold}) begin
      d.late = 1'b0;
    end
    if (showing && active && step && !fifo_valid) begin
      d.underrun_flag = 1'b1;
    end else if (clear_underrun) begin
      d.underrun_flag = 1'b0;
    end
    if (clear_field_one_done) begin
      d.field_one_done = 1'b0;
    end
    if (clear_field_two_done) begin
      d.field_two_done = 1'b0;
    end
    if (clear_frame_done) begin
      d.frame_done = 1'b0;
    end
    if (clear_display_complete) begin
      d.display_complete_flag = 1'b0;
    end
    if (clear_not_ack) begin
      d.completion_not_acknowledged = 1'b0;
    end
    // set on the edge that registers the last pixel out
    if (showing && frame_end) begin
      d.display_complete_flag = 1'b1;
      if (!continuous_select && (q.frame_done || q.field_one_done || q.field_two_done)) begin
        d.completion_not_acknowledged = 1'b1;
      end
      if (frame_select) begin
        d.frame_done = 1'b1;
      end else if (q.field_two) begin
        d.field_two_done = 1'b1;
      end else begin
        d.field_one_done = 1'b1;
      end
      d.state = continuous_select ? ST_SHOW : ST_HOLD;
      d.evt_left = q.field_two ? field_one_event_count : field_two_event_count;
    end
    // disable wins over a completion that would keep showing
    if (block_disable && d.state != ST_IDLE && d.state != ST_WAIT_FRAME) begin
      d.state = display_enable_bit ? ST_WAIT_FRAME : ST_IDLE;
    end
    d.irq = (d.display_complete_flag && complete_irq_enable) || (d.underrun_flag && underrun_irq_enable)
      || d.completion_not_acknowledged;
    if (rst) begin
      d = '0;
      d.state = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    q <= d;
  end

  // Output map
  assign luma_dma_event = q.luma_dma_event;
  assign pixel_out = q.pixel_out;
  assign pixel_valid = q.pixel_valid;
  assign hsync = q.hsync;
  assign vsync = q.vsync;
  assign vblank = q.vblank;
  assign field_id = q.field_two;
  assign frame_pixel_counter = q.pix;
  assign frame_line_counter = q.line;
  assign field_one_done = q.field_one_done;
  assign field_two_done = q.field_two_done;
  assign frame_done = q.frame_done;
  assign display_complete_flag = q.display_complete_flag;
  assign completion_not_acknowledged = q.completion_not_acknowledged;
  assign underrun_flag = q.underrun_flag;
  assign interrupt = q.irq;
endmodule : raw_display_channel

/* raw_display_channel_assertions.sv */
// Purpose: Port-level assertions for the raw display channel
// Assumes: Timing settings held stable while running
// Notes: Bound from the bench top file
`timescale 1ns/100ps
`include "raw_display_map.svh"
module raw_display_channel_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic block_disable,
  input wire logic pixel_increment_rate,
  input wire logic [`CNT_W-1:0] frame_width,
  input wire logic [`CNT_W-1:0] frame_height,
  input wire logic [`CNT_W-1:0] hsync_width,
  input wire logic complete_irq_enable,
  input wire logic underrun_irq_enable,
  input wire logic clear_frame_done,
  input wire logic clear_underrun,
  input wire logic luma_fifo_window_ready,
  input wire logic luma_dma_event,
  input wire logic hsync,
  input wire logic [`CNT_W-1:0] frame_pixel_counter,
  input wire logic [`CNT_W-1:0] frame_line_counter,
  input wire logic field_one_done,
  input wire logic field_two_done,
  input wire logic frame_done,
  input wire logic display_complete_flag,
  input wire logic completion_not_acknowledged,
  input wire logic underrun_flag,
  input wire logic interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic at_end;
  logic any_done;
  logic quiet_q;
  logic [`CNT_W-1:0] hs_run_q;
  // Last pixel of a frame and any completion flag
  assign at_end = frame_line_counter == frame_height && frame_pixel_counter == frame_width;
  assign any_done = field_one_done || field_two_done || frame_done;
  sequence s_frame_end;
    at_end && !pixel_increment_rate;
  endsequence
  sequence s_irq_off;
    !complete_irq_enable && !underrun_irq_enable && !completion_not_acknowledged;
  endsequence
  // Sync pulse length and quiet span after disable drops
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_run_q <= '0;
      quiet_q <= 1'b0;
    end else begin
      hs_run_q <= hsync ? hs_run_q + 1'b1 : '0;
      quiet_q <= at_end ? 1'b0 : ($fell(block_disable) ? 1'b1 : quiet_q);
    end
  end
  a_pixel_bound: assert property (frame_pixel_counter <= frame_width) else $error("pixel count past width");
  a_frame_wrap: assert property (s_frame_end |=> frame_pixel_counter == 0 && frame_line_counter == 0)
    else $error("counters did not wrap");
  a_done_cause: assert property ($rose(any_done) |-> $past(at_end)) else $error("done flag off frame end");
  a_done_status: assert property ($rose(any_done) |-> display_complete_flag) else $error("complete flag missing");
  a_flag_holds: assert property (frame_done && !clear_frame_done |=> frame_done) else $error("done flag lost");
  a_flag_clears: assert property (frame_done && clear_frame_done && !at_end |=> !frame_done)
    else $error("done flag not cleared");
  a_irq_gated: assert property (s_irq_off [*2] |-> !interrupt) else $error("interrupt while masked");
  a_dis_quiet: assert property (block_disable && $past(block_disable) |-> !luma_dma_event)
    else $error("event while disabled");
  a_dis_refuse: assert property (block_disable |-> !luma_fifo_window_ready) else $error("write taken while disabled");
  a_event_wait: assert property (quiet_q |-> !luma_dma_event) else $error("event in re-enable frame");
  a_hsync_len: assert property ($fell(hsync) && !pixel_increment_rate |-> hs_run_q == hsync_width)
    else $error("hsync width wrong");
  a_urun_holds: assert property (underrun_flag && !clear_underrun |=> underrun_flag) else $error("underrun lost");
  c_frame_done: cover property (s_frame_end ##1 display_complete_flag);
endmodule : raw_display_channel_assertions

/* raw_display_map.svh */
// Purpose: Constants for the raw video display channel
// Assumes: 100 MHz pixel clock, counters 12 bits wide
// Notes: Field positions of the display mode code
`ifndef RAW_DISPLAY_MAP_SVH
`define RAW_DISPLAY_MAP_SVH
`define CNT_W 12
`define SAMPLE_W 20
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define THR_W 5
`define EVT_W 12
`define MODE_W 3
`define MODE_RAW_NARROW 2'b01
`define MODE_RAW_WIDE 2'b11
`define FIFO_FLUSH_CYCLES 1
`endif

/* raw_display_pkg.sv */
// Purpose: Types for the raw video display channel
// Assumes: Included map header supplies widths
// Notes: Channel state outside the FIFO lives in one packed struct
`include "raw_display_map.svh"
package raw_display_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_FRAME,
    ST_SHOW,
    ST_HOLD
  } disp_state_t;
  typedef struct packed {
    logic [`CNT_W-1:0] pix;
    logic [`CNT_W-1:0] line;
    logic pix_phase;
    logic field_two;
    logic hsync;
    logic [`CNT_W-1:0] hsync_cnt;
    logic vblank;
    logic vsync;
    disp_state_t state;
    logic blk_prev;
    logic rearm;
    logic [`EVT_W-1:0] evt_left;
    logic [`THR_W:0] since_req;
    logic late;
    logic field_one_done;
    logic field_two_done;
    logic frame_done;
    logic display_complete_flag;
    logic completion_not_acknowledged;
    logic underrun_flag;
    logic irq;
    logic luma_dma_event;
    logic [`SAMPLE_W-1:0] pixel_out;
    logic pixel_valid;
    logic pop;
  } disp_reg_t;
endpackage : raw_display_pkg

/* tb_raw_display_channel.sv */
// Purpose: Self-checking bench for the raw display channel
// Assumes: Frame of 16 pixels by 6 lines
// Notes: Controls are driven one unit after each rising edge
`timescale 1ns/100ps
`include "raw_display_map.svh"
module tb_raw_display_channel;
  localparam int FRAME = 96;
  logic clk, rst, display_enable_bit, block_disable, continuous_select, frame_select, field_one_select;
  logic field_two_select, ten_bit_unpack, pixel_increment_rate, underrun_irq_enable, complete_irq_enable;
  logic clear_field_one_done, clear_field_two_done, clear_frame_done, clear_underrun, clear_not_ack;
  logic clear_display_complete, luma_fifo_window_valid, luma_fifo_window_ready, luma_dma_event, pixel_valid;
  logic hsync, vsync, vblank, field_id, field_one_done, field_two_done, frame_done, display_complete_flag;
  logic completion_not_acknowledged, underrun_flag, interrupt, got_px;
  logic [`MODE_W-1:0] display_format_select;
  logic [`THR_W-1:0] display_fifo_threshold;
  logic [`CNT_W-1:0] frame_width, frame_height, hblank_start, hblank_stop, hsync_start_pixel, hsync_width;
  logic [`CNT_W-1:0] frame_pixel_counter, frame_line_counter, p0;
  logic [2*`CNT_W-1:0] vblank_start_1, vblank_stop_1, vblank_start_2, vblank_stop_2, vsync_start_1, vsync_stop_1;
  logic [2*`CNT_W-1:0] vsync_start_2, vsync_stop_2, field_one_start_pos, field_two_start_pos;
  logic [`EVT_W-1:0] field_one_event_count, field_two_event_count;
  logic [`SAMPLE_W-1:0] default_value, luma_fifo_window, pixel_out, first_px;
  logic [15:0] dma_delay;
  int num_errors, checks, cnt, rem, seen;
  raw_display_channel i_raw_display_channel (.*);
  dma_source_model i_dma_source_model (.reprogram(block_disable), .*);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : check
  task automatic clear_all(input logic v);
    {clear_field_one_done, clear_field_two_done, clear_frame_done} = {3{v}};
    {clear_underrun, clear_not_ack, clear_display_complete} = {3{v}};
  endtask : clear_all
  task automatic end_sim;
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // First streamed pixel after loads begin
  always @(posedge clk) begin
    if (pixel_valid === 1'b1 && !got_px && seen > 0 && pixel_out !== default_value) begin
      first_px <= pixel_out;
      got_px <= 1'b1;
    end
    if (luma_dma_event === 1'b1) seen <= seen + 1;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {num_errors, checks, seen, got_px} = '0;
    {rst, block_disable, continuous_select, field_one_select, field_two_select, complete_irq_enable} = 6'h3f;
    {display_enable_bit, frame_select, ten_bit_unpack, pixel_increment_rate, underrun_irq_enable} = '0;
    clear_all(1'b0);
    display_format_select = 3'b110;
    display_fifo_threshold = 5'h04;
    {frame_width, frame_height, hblank_start, hblank_stop} = {12'h00f, 12'h005, 12'h00c, 12'h004};
    {hsync_start_pixel, hsync_width} = {12'h003, 12'h004};
    {vblank_start_1, vblank_stop_1, vsync_start_1, vsync_stop_1} = {{2{24'hfff_fff}}, 24'h000_004, 24'h000_008};
    {vblank_start_2, vblank_stop_2, vsync_start_2, vsync_stop_2} = {4{24'hfff_fff}};
    {field_one_start_pos, field_two_start_pos} = {24'h000_000, 24'h003_000};
    {field_one_event_count, field_two_event_count} = {12'h00c, 12'h00c};
    default_value = 20'h00000;
    dma_delay = 16'h0000;
    tick(20);
    rst = 1'b0;
    check({frame_done, display_complete_flag, underrun_flag, interrupt}, 4'h0);
    for (cnt = 0; cnt < 40 && frame_pixel_counter !== frame_width; cnt++) tick(1);
    p0 = frame_line_counter;
    tick(1);
    check({frame_pixel_counter, frame_line_counter}, {12'h000, (p0 == frame_height) ? 12'h000 : p0 + 1'b1});
    for (cnt = 0; cnt < 2 * FRAME && {frame_line_counter, frame_pixel_counter} !== 24'h000_006; cnt++) tick(1);
    check({vsync, vblank, field_id}, 3'b100);
    for (cnt = 0; cnt < 2 * FRAME && {frame_line_counter, frame_pixel_counter} !== 24'h003_002; cnt++) tick(1);
    check(field_id, 1'b1);
    display_enable_bit = 1'b1;
    tick(2 * FRAME);
    check(seen, 0);
    check(luma_fifo_window_ready, 1'b0);
    block_disable = 1'b0;
    rem = (int'(frame_height) - int'(frame_line_counter)) * 16 + 15 - int'(frame_pixel_counter) + 1;
    for (cnt = 0; cnt < 4 * FRAME && luma_dma_event !== 1'b1; cnt++) tick(1);
    check(cnt >= rem && cnt < 4 * FRAME, 1'b1);
    for (cnt = 0; cnt < 4 * FRAME && display_complete_flag !== 1'b1; cnt++) tick(1);
    check(display_complete_flag, 1'b1);
    tick(1);
    check(interrupt, 1'b1);
    check(first_px, 20'h00001);
    clear_all(1'b1);
    tick(1);
    clear_all(1'b0);
    tick(1);
    check({field_one_done, field_two_done, frame_done, display_complete_flag}, 4'h0);
    continuous_select = 1'b0;
    for (cnt = 0; cnt < 6 * FRAME && completion_not_acknowledged !== 1'b1; cnt++) tick(1);
    check(completion_not_acknowledged, 1'b1);
    continuous_select = 1'b1;
    complete_irq_enable = 1'b0;
    dma_delay = 16'hffff;
    clear_all(1'b1);
    tick(1);
    clear_all(1'b0);
    for (cnt = 0; cnt < 4 * FRAME && underrun_flag !== 1'b1; cnt++) tick(1);
    check(underrun_flag, 1'b1);
    tick(2);
    check(interrupt, 1'b0);
    for (cnt = 0, rem = 0; cnt < 50; cnt++) begin
      tick(1);
      rem += (pixel_valid === 1'b1);
    end
    check(rem > 0, 1'b1);
    underrun_irq_enable = 1'b1;
    tick(2);
    check(interrupt, 1'b1);
    block_disable = 1'b1;
    dma_delay = 16'h0000;
    tick(1);
    check(luma_fifo_window_ready, 1'b0);
    clear_all(1'b1);
    tick(1);
    clear_all(1'b0);
    block_disable = 1'b0;
    rem = seen;
    tick(3 * FRAME);
    check(seen > rem, 1'b1);
    pixel_increment_rate = 1'b1;
    tick(2);
    p0 = frame_pixel_counter;
    for (cnt = 0; cnt < 4 && frame_pixel_counter === p0; cnt++) tick(1);
    p0 = frame_pixel_counter;
    tick(1);
    check(frame_pixel_counter, p0);
    tick(1);
    check(frame_pixel_counter, (p0 == frame_width) ? 12'h000 : p0 + 1'b1);
    end_sim();
  end
endmodule : tb_raw_display_channel
bind raw_display_channel raw_display_channel_assertions i_raw_display_channel_assertions (.*);
